// ==== verilog/au9_uart_top.v ====
// asynchronous serial port with 9-bit characters, wishbone register slave
// assumes: classic wishbone master, receive_pin asynchronous to ref_clk
//
// Overview of operation
// - nine-bit select shifts nine data bits out, stored ninth bit as msb
// - data write moves all nine bits toward the shift register at once
// - transmit enable with async mode and port enable sets buffer empty
// - transmit irq raised when its enable, peripheral and global enables set
// - loading data while the transmitter is enabled starts a character
// - a set ninth bit marks the byte as an address
// - receive input sampled at sixteen times baud, one shift per bit
// - complete character goes straight into a two-entry fifo
// - receiver runs only with continuous receive, async mode, port enable
// - start edge checked at half bit; high level aborts silently
// - each later bit taken one bit time on by majority vote
// - stop sample low sets framing status, high clears it
// - after stop the character is pushed; data read pops the oldest
// - data available follows fifo occupancy while enabled, not writable
// - receive irq needs all three enables; flag ignores enables
// - framing status stored per entry, oldest entry shown
// - framing error keeps receiving; status advances with each read
// - port disable resets and clears framing; receive disable keeps it
// - framing error alone raises no interrupt
// - after overrun no further characters are accepted until cleared
// - lsb first, low start bit, high stop bit, idle high
// - buffer empty set while enabled and holding register empty, read only
// - overrun on third character with two unread; cleared by disables
`timescale 1ns/1ps
`default_nettype none
`include "au9_consts.vh"
module au9_uart_top (
    // clock and reset
    input wire ref_clk,
    input wire reset_n,
    // wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [5:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // serial pins
    input wire receive_pin,
    output reg tx_pin,
    output reg tx_pin_oe_n,
    // interrupt request
    output reg irq_request
);
    localparam ST_IDLE = 2'b00;
    localparam ST_START = 2'b01;
    localparam ST_DATA = 2'b10;
    localparam ST_STOP = 2'b11;

    // control bits
    reg nine_bit_tx_select;
    reg transmitter_enable;
    reg sync_mode;
    reg high_speed_baud;
    reg tx_ninth_bit;
    reg serial_port_enable;
    reg nine_bit_rx_select;
    reg continuous_rx_enable;
    reg address_detect_enable;
    reg tx_invert_select;
    reg wide_divisor_select;
    reg global_irq_enable;
    reg peripheral_irq_enable;
    reg rx_irq_enable;
    reg tx_irq_enable;
    reg [7:0] divisor_low;
    reg [7:0] divisor_high;
    reg [8:0] tx_data_holding;
    reg hold_full;
    reg overrun_error_flag;

    // receive fifo
    reg [9:0] fifo_mem [0:1];
    reg fifo_wr;
    reg fifo_rd;
    reg [1:0] fifo_cnt;

    // receiver
    reg rx_s1;
    reg rx_s2;
    reg rx_s3;
    reg rx_level;
    reg rx_level_d;
    reg [1:0] rx_state;
    reg [3:0] ovs_cnt;
    reg [2:0] votes;
    reg [3:0] bits_got;
    reg rx_nine;
    reg [8:0] rx_shift_reg;

    // bus and status wiring
    reg [7:0] rd_byte;
    wire tick16;
    wire tsr_busy;
    wire tsr_line;
    wire [15:0] divisor;
    wire wb_req;
    wire wr_lane;
    wire rd_pop;
    wire tx_active;
    wire rx_active;
    wire tsr_load;
    wire tx_buffer_empty_flag;
    wire rx_data_avail_flag;
    wire [9:0] fifo_top;
    wire framing_error_flag;
    wire rx_ninth_bit;
    wire falling;
    wire vote_now;
    wire eval_now;
    wire stop_done;
    wire [9:0] rx_word;
    wire accept;
    wire do_push;
    wire do_pop;
    wire overrun_set;

    // three-sample majority
    function majority3;
        input [2:0] v;
        begin
            majority3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
        end
    endfunction

    // bus request decode
    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_lane = wb_req & wb_we_i & wb_sel_i[0];
    assign rd_pop = wb_req & ~wb_we_i & (wb_adr_i == `AU9_ADR_RX_DATA);

    // enable qualification
    assign tx_active = transmitter_enable & ~sync_mode & serial_port_enable;
    assign rx_active = continuous_rx_enable & ~sync_mode & serial_port_enable;
    assign tsr_load = tx_active & hold_full & ~tsr_busy;
    assign tx_buffer_empty_flag = tx_active & ~hold_full;
    assign rx_data_avail_flag = rx_active & (fifo_cnt != `AU9_FIFO_EMPTY);

    assign fifo_top = fifo_mem[fifo_rd];
    assign framing_error_flag = (fifo_cnt != `AU9_FIFO_EMPTY) & fifo_top[9];
    assign rx_ninth_bit = (fifo_cnt != `AU9_FIFO_EMPTY) & fifo_top[8];

    assign divisor = wide_divisor_select ? {divisor_high, divisor_low}
                                         : {`AU9_ZERO_BYTE, divisor_low};

    // oversampling tick
    au9_baud_gen u_baud (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .run(serial_port_enable),
        .divisor(divisor),
        .tick(tick16)
    );

    // transmit shifter
    au9_tx_shift u_tx (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .active(tx_active),
        .tick(tick16),
        .nine_bit(nine_bit_tx_select),
        .load(tsr_load),
        .load_data(tx_data_holding),
        .busy(tsr_busy),
        .line(tsr_line)
    );

    // register read mux
    always @* begin
        rd_byte = `AU9_ZERO_BYTE;
        case (wb_adr_i)
            `AU9_ADR_TX_STATUS: begin
                rd_byte[`AU9_BIT_NINE_TX] = nine_bit_tx_select;
                rd_byte[`AU9_BIT_TX_ENABLE] = transmitter_enable;
                rd_byte[`AU9_BIT_SYNC_MODE] = sync_mode;
                rd_byte[`AU9_BIT_HIGH_SPEED] = high_speed_baud;
                rd_byte[`AU9_BIT_SHIFT_EMPTY] = ~tsr_busy;
                rd_byte[`AU9_BIT_TX_NINTH] = tx_ninth_bit;
            end
            `AU9_ADR_RX_STATUS: begin
                rd_byte[`AU9_BIT_PORT_ENABLE] = serial_port_enable;
                rd_byte[`AU9_BIT_NINE_RX] = nine_bit_rx_select;
                rd_byte[`AU9_BIT_CONT_RX] = continuous_rx_enable;
                rd_byte[`AU9_BIT_ADDR_DETECT] = address_detect_enable;
                rd_byte[`AU9_BIT_FRAME_ERR] = framing_error_flag;
                rd_byte[`AU9_BIT_OVERRUN] = overrun_error_flag;
                rd_byte[`AU9_BIT_RX_NINTH] = rx_ninth_bit;
            end
            `AU9_ADR_BAUD_CTRL: begin
                rd_byte[`AU9_BIT_RX_IDLE] = (rx_state == ST_IDLE);
                rd_byte[`AU9_BIT_TX_INVERT] = tx_invert_select;
                rd_byte[`AU9_BIT_WIDE_DIV] = wide_divisor_select;
            end
            `AU9_ADR_DIV_LOW: rd_byte = divisor_low;
            `AU9_ADR_DIV_HIGH: rd_byte = divisor_high;
            `AU9_ADR_TX_DATA: rd_byte = tx_data_holding[7:0];
            `AU9_ADR_RX_DATA: rd_byte = fifo_top[7:0];
            `AU9_ADR_INT_MAIN: begin
                rd_byte[`AU9_BIT_GLOBAL_IRQ] = global_irq_enable;
                rd_byte[`AU9_BIT_PERIPH_IRQ] = peripheral_irq_enable;
            end
            `AU9_ADR_PER_ENA: begin
                rd_byte[`AU9_BIT_RX_IRQ] = rx_irq_enable;
                rd_byte[`AU9_BIT_TX_IRQ] = tx_irq_enable;
            end
            `AU9_ADR_PER_FLAG: begin
                rd_byte[`AU9_BIT_RX_IRQ] = rx_data_avail_flag;
                rd_byte[`AU9_BIT_TX_IRQ] = tx_buffer_empty_flag;
            end
            default: rd_byte = `AU9_ZERO_BYTE;
        endcase
    end

    // wishbone answer: ack one cycle after the request, unmapped reads zero
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_req && !wb_we_i) begin
                wb_dat_o <= {`AU9_ZERO_PAD, rd_byte};
            end
        end
    end

    // software-written control bits; flags are not writable
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            nine_bit_tx_select <= 1'b0;
            transmitter_enable <= 1'b0;
            sync_mode <= 1'b0;
            high_speed_baud <= 1'b0;
            tx_ninth_bit <= 1'b0;
            serial_port_enable <= 1'b0;
            nine_bit_rx_select <= 1'b0;
            continuous_rx_enable <= 1'b0;
            address_detect_enable <= 1'b0;
            tx_invert_select <= 1'b0;
            wide_divisor_select <= 1'b0;
            global_irq_enable <= 1'b0;
            peripheral_irq_enable <= 1'b0;
            rx_irq_enable <= 1'b0;
            tx_irq_enable <= 1'b0;
            divisor_low <= `AU9_ZERO_BYTE;
            divisor_high <= `AU9_ZERO_BYTE;
        end else if (wr_lane) begin
            case (wb_adr_i)
                `AU9_ADR_TX_STATUS: begin
                    nine_bit_tx_select <= wb_dat_i[`AU9_BIT_NINE_TX];
                    transmitter_enable <= wb_dat_i[`AU9_BIT_TX_ENABLE];
                    sync_mode <= wb_dat_i[`AU9_BIT_SYNC_MODE];
                    high_speed_baud <= wb_dat_i[`AU9_BIT_HIGH_SPEED];
                    tx_ninth_bit <= wb_dat_i[`AU9_BIT_TX_NINTH];
                end
                `AU9_ADR_RX_STATUS: begin
                    serial_port_enable <= wb_dat_i[`AU9_BIT_PORT_ENABLE];
                    nine_bit_rx_select <= wb_dat_i[`AU9_BIT_NINE_RX];
                    continuous_rx_enable <= wb_dat_i[`AU9_BIT_CONT_RX];
                    address_detect_enable <= wb_dat_i[`AU9_BIT_ADDR_DETECT];
                end
                `AU9_ADR_BAUD_CTRL: begin
                    tx_invert_select <= wb_dat_i[`AU9_BIT_TX_INVERT];
                    wide_divisor_select <= wb_dat_i[`AU9_BIT_WIDE_DIV];
                end
                `AU9_ADR_DIV_LOW: divisor_low <= wb_dat_i[7:0];
                `AU9_ADR_DIV_HIGH: divisor_high <= wb_dat_i[7:0];
                `AU9_ADR_INT_MAIN: begin
                    global_irq_enable <= wb_dat_i[`AU9_BIT_GLOBAL_IRQ];
                    peripheral_irq_enable <= wb_dat_i[`AU9_BIT_PERIPH_IRQ];
                end
                `AU9_ADR_PER_ENA: begin
                    rx_irq_enable <= wb_dat_i[`AU9_BIT_RX_IRQ];
                    tx_irq_enable <= wb_dat_i[`AU9_BIT_TX_IRQ];
                end
                default: begin
                end
            endcase
        end
    end

    // transmit holding register; a write while loading still wins
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_data_holding <= 9'h000;
            hold_full <= 1'b0;
        end else if (wr_lane && wb_adr_i == `AU9_ADR_TX_DATA) begin
            tx_data_holding <= {tx_ninth_bit, wb_dat_i[7:0]};
            hold_full <= 1'b1;
        end else if (!serial_port_enable || tsr_load) begin
            hold_full <= 1'b0;
        end
    end

    // pin drive and interrupt request, all registered
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_pin <= 1'b1;
            tx_pin_oe_n <= 1'b1;
            irq_request <= 1'b0;
        end else begin
            tx_pin <= serial_port_enable ? (tsr_line ^ tx_invert_select) : 1'b1;
            tx_pin_oe_n <= ~serial_port_enable;
            irq_request <= global_irq_enable & peripheral_irq_enable &
                           ((tx_irq_enable & tx_buffer_empty_flag) |
                            (rx_irq_enable & rx_data_avail_flag));
        end
    end

    // three-stage input synchroniser with agreement filter
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_s1 <= 1'b1;
            rx_s2 <= 1'b1;
            rx_s3 <= 1'b1;
            rx_level <= 1'b1;
            rx_level_d <= 1'b1;
        end else begin
            rx_s1 <= receive_pin;
            rx_s2 <= rx_s1;
            rx_s3 <= rx_s2;
            if (rx_s2 == rx_s3) begin
                rx_level <= rx_s3;
            end
            rx_level_d <= rx_level;
        end
    end

    // receiver timing terms
    assign falling = rx_level_d & ~rx_level;
    assign eval_now = tick16 & (ovs_cnt == `AU9_VOTE_LAST);
    assign vote_now = majority3({votes[1:0], rx_level});
    assign stop_done = rx_active & (rx_state == ST_STOP) & eval_now;
    assign rx_word = {~vote_now,
                      (rx_nine ? rx_shift_reg : {1'b0, rx_shift_reg[8:1]})};
    assign accept = ~address_detect_enable | (rx_nine & rx_shift_reg[8]);
    assign do_push = stop_done & accept & ~overrun_error_flag &
                     ((fifo_cnt != `AU9_FIFO_FULL) | rd_pop);
    assign overrun_set = stop_done & accept & ~overrun_error_flag &
                         (fifo_cnt == `AU9_FIFO_FULL) & ~rd_pop;
    assign do_pop = rd_pop & (fifo_cnt != `AU9_FIFO_EMPTY);

    // receive bit recovery state machine
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_state <= ST_IDLE;
            ovs_cnt <= 4'h0;
            votes <= 3'h0;
            bits_got <= 4'h0;
            rx_nine <= 1'b0;
            rx_shift_reg <= 9'h000;
        end else if (!rx_active) begin
            rx_state <= ST_IDLE;
            ovs_cnt <= 4'h0;
        end else begin
            if (tick16 && rx_state != ST_IDLE) begin
                ovs_cnt <= ovs_cnt + 4'h1;
                if (ovs_cnt >= `AU9_VOTE_FIRST && ovs_cnt <= `AU9_VOTE_LAST) begin
                    votes <= {votes[1:0], rx_level};
                end
            end
            case (rx_state)
                ST_IDLE: begin
                    if (falling) begin
                        rx_state <= ST_START;
                        ovs_cnt <= 4'h0;
                        bits_got <= 4'h0;
                        rx_nine <= nine_bit_rx_select;
                    end
                end
                ST_START: begin
                    if (eval_now) begin
                        rx_state <= vote_now ? ST_IDLE : ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (eval_now) begin
                        rx_shift_reg <= {vote_now, rx_shift_reg[8:1]};
                        bits_got <= bits_got + 4'h1;
                        if (bits_got + 4'h1 ==
                            (rx_nine ? `AU9_BITS_NINE : `AU9_BITS_EIGHT)) begin
                            rx_state <= ST_STOP;
                        end
                    end
                end
                ST_STOP: begin
                    if (eval_now) begin
                        rx_state <= ST_IDLE;
                    end
                end
                default: rx_state <= ST_IDLE;
            endcase
        end
    end

    // fifo storage with per-entry framing status
    always @(posedge ref_clk) begin
        if (do_push) begin
            fifo_mem[fifo_wr] <= rx_word;
        end
    end

    // fifo pointers; port disable empties it
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            fifo_wr <= 1'b0;
            fifo_rd <= 1'b0;
            fifo_cnt <= `AU9_FIFO_EMPTY;
        end else if (!serial_port_enable) begin
            fifo_wr <= 1'b0;
            fifo_rd <= 1'b0;
            fifo_cnt <= `AU9_FIFO_EMPTY;
        end else begin
            if (do_push) begin
                fifo_wr <= ~fifo_wr;
            end
            if (do_pop) begin
                fifo_rd <= ~fifo_rd;
            end
            if (do_push && !do_pop) begin
                fifo_cnt <= fifo_cnt + 2'h1;
            end else if (do_pop && !do_push) begin
                fifo_cnt <= fifo_cnt - 2'h1;
            end
        end
    end

    // overrun flag: set wins over the clear
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            overrun_error_flag <= 1'b0;
        end else begin
            if (!serial_port_enable || !continuous_rx_enable) begin
                overrun_error_flag <= 1'b0;
            end
            if (overrun_set) begin
                overrun_error_flag <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== common/au9_consts.vh ====
// constants shared by the 9-bit asynchronous serial port files
// assumes: included by bare name from the top and transmit shifter design files
`ifndef AU9_CONSTS_VH
`define AU9_CONSTS_VH

// register byte addresses on the wishbone bus
`define AU9_ADR_TX_STATUS 6'h00
`define AU9_ADR_RX_STATUS 6'h04
`define AU9_ADR_BAUD_CTRL 6'h08
`define AU9_ADR_DIV_LOW 6'h0c
`define AU9_ADR_DIV_HIGH 6'h10
`define AU9_ADR_TX_DATA 6'h14
`define AU9_ADR_RX_DATA 6'h18
`define AU9_ADR_INT_MAIN 6'h1c
`define AU9_ADR_PER_ENA 6'h20
`define AU9_ADR_PER_FLAG 6'h24

// tx_status_control fields
`define AU9_BIT_NINE_TX 6
`define AU9_BIT_TX_ENABLE 5
`define AU9_BIT_SYNC_MODE 4
`define AU9_BIT_HIGH_SPEED 2
`define AU9_BIT_SHIFT_EMPTY 1
`define AU9_BIT_TX_NINTH 0

// rx_status_control fields
`define AU9_BIT_PORT_ENABLE 7
`define AU9_BIT_NINE_RX 6
`define AU9_BIT_CONT_RX 4
`define AU9_BIT_ADDR_DETECT 3
`define AU9_BIT_FRAME_ERR 2
`define AU9_BIT_OVERRUN 1
`define AU9_BIT_RX_NINTH 0

// baud_control fields
`define AU9_BIT_RX_IDLE 6
`define AU9_BIT_TX_INVERT 4
`define AU9_BIT_WIDE_DIV 3

// interrupt enable and flag fields
`define AU9_BIT_GLOBAL_IRQ 7
`define AU9_BIT_PERIPH_IRQ 6
`define AU9_BIT_RX_IRQ 5
`define AU9_BIT_TX_IRQ 4

// oversampling and framing counts
`define AU9_OVS_LAST 4'hf
`define AU9_VOTE_FIRST 4'h7
`define AU9_VOTE_LAST 4'h9
`define AU9_BITS_EIGHT 4'h8
`define AU9_BITS_NINE 4'h9
`define AU9_TX_FRAME_EIGHT 4'h9
`define AU9_TX_FRAME_NINE 4'ha
`define AU9_FIFO_EMPTY 2'h0
`define AU9_FIFO_FULL 2'h2
`define AU9_ZERO_BYTE 8'h00
`define AU9_ZERO_PAD 24'h000000

`endif

// ==== verilog/au9_baud_gen.v ====
// oversampling tick generator: one tick every divisor+1 clocks
// assumes: divisor held stable by software while the port runs
`timescale 1ns/1ps
`default_nettype none
module au9_baud_gen (
    // clock and reset
    input wire ref_clk,
    input wire reset_n,
    // control
    input wire run,
    input wire [15:0] divisor,
    // sixteen-times baud tick
    output reg tick
);
    reg [15:0] count;

    // down-free up counter, restarts when stopped
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            count <= 16'h0000;
            tick <= 1'b0;
        end else if (!run) begin
            count <= 16'h0000;
            tick <= 1'b0;
        end else if (count >= divisor) begin
            count <= 16'h0000;
            tick <= 1'b1;
        end else begin
            count <= count + 16'h0001;
            tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== verilog/au9_tx_shift.v ====
// transmit shift register: start bit, 8 or 9 data bits lsb first, stop bit
// assumes: tick is the sixteen-times oversampling tick, load only when not busy
`timescale 1ns/1ps
`default_nettype none
`include "au9_consts.vh"
module au9_tx_shift (
    // clock and reset
    input wire ref_clk,
    input wire reset_n,
    // control
    input wire active,
    input wire tick,
    input wire nine_bit,
    // character load
    input wire load,
    input wire [8:0] load_data,
    // status and line
    output reg busy,
    output reg line
);
    reg [9:0] tx_shift_reg;
    reg [3:0] bits_left;
    reg [3:0] ovs_cnt;

    // frame sequencer, aborted when the transmitter is off
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_shift_reg <= 10'h3ff;
            bits_left <= 4'h0;
            ovs_cnt <= 4'h0;
            busy <= 1'b0;
            line <= 1'b1;
        end else if (!active) begin
            busy <= 1'b0;
            line <= 1'b1;
        end else if (load) begin
            tx_shift_reg <= {1'b1, (nine_bit ? load_data[8] : 1'b1), load_data[7:0]};
            bits_left <= nine_bit ? `AU9_TX_FRAME_NINE : `AU9_TX_FRAME_EIGHT;
            ovs_cnt <= 4'h0;
            busy <= 1'b1;
            line <= 1'b0;
        end else if (busy && tick) begin
            ovs_cnt <= ovs_cnt + 4'h1;
            if (ovs_cnt == `AU9_OVS_LAST) begin
                if (bits_left == 4'h0) begin
                    busy <= 1'b0;
                end else begin
                    line <= tx_shift_reg[0];
                    tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
                    bits_left <= bits_left - 4'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ==== test/au9_uart_checker.sv ====
// port-level assertions for the 9-bit serial port top
// assumes: one clock domain, bound onto au9_uart_top
`timescale 1ns/1ps
`default_nettype none
module au9_uart_checker (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // bus and pins
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic tx_pin,
    input wire logic tx_pin_oe_n,
    input wire logic irq_request
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // bus handshake, read format, serial line timing and interrupt gating
    ack_follows_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    ack_has_req_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    read_upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
        else $error("upper read bits set");
    idle_when_off_a:
        assert property (tx_pin_oe_n |-> tx_pin) else $error("line not idle");
    start_width_a:
        assert property ($fell(tx_pin) && !tx_pin_oe_n |-> !tx_pin [*8]) else $error("short start");
    bit_hold_a:
        assert property ($changed(tx_pin) && !tx_pin_oe_n |=> $stable(tx_pin) [*7])
        else $error("short bit");
    irq_needs_port_a:
        assert property (irq_request |-> !tx_pin_oe_n) else $error("irq while port off");
endmodule
bind au9_uart_top au9_uart_checker chk_i (.ref_clk(ref_clk), .reset_n(reset_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .tx_pin(tx_pin), .tx_pin_oe_n(tx_pin_oe_n), .irq_request(irq_request));
`default_nettype wire

// ==== test/au9_serial_peer.sv ====
// remote serial end: sends frames to the receiver, captures transmitted ones
// assumes: divisor 0, so one bit lasts 16 clocks; line idles high
`timescale 1ns/1ps
`default_nettype none
module au9_serial_peer (
    // clock
    input wire logic clk,
    // serial lines
    input wire logic tx_line,
    output var logic rx_line
);
    initial rx_line = 1'b1;
    // low start, lsb first, chosen stop level, then idle high
    task send(input logic [7:0] v, input logic stop);
        for (int i = -1; i < 10; i++) begin
            rx_line <= i < 0 ? 1'b0 : i < 8 ? v[i] : i == 8 ? stop : 1'b1;
            repeat (16) @(posedge clk);
        end
    endtask
    // mid-bit capture of nine data bits lsb first and the stop bit
    task recv(output logic [8:0] d, output logic stop);
        @(negedge tx_line);
        repeat (8) @(posedge clk);
        for (int i = 0; i < 10; i++) begin
            repeat (16) @(posedge clk);
            if (i < 9) d[i] = tx_line;
            else stop = tx_line;
        end
    endtask
endmodule
`default_nettype wire

// ==== test/test_async_uart_9bit_txrx.sv ====
// self-checking bench for the 9-bit serial port
// assumes: peer model on the serial lines, divisor left at 0
`timescale 1ns/1ps
`default_nettype none
module test_async_uart_9bit_txrx;
    logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, ack, tx, oen, irq, rx, stp;
    logic [5:0] adr = 0;
    logic [31:0] wdat = 0, rdat, q;
    logic [8:0] d;
    int num_errors = 0, compares = 0, ticks = 0;
    // rows: {write, 0, address, data, expected read}
    logic [23:0] rows [20] = '{24'h000002, 24'h848000, 24'h806000, 24'h240010, 24'ha4ff00,
        24'h240010, 24'hac5500, 24'h2c0000, 24'ha01000, 24'h9cc000, 24'h806100, 24'h849000,
        24'h040092, 24'h18003c, 24'h040096, 24'h1800c3, 24'h240010, 24'h848000, 24'h849000,
        24'h040090};
    always #2 clk = ~clk;
    au9_uart_top dut (.ref_clk(clk), .reset_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .receive_pin(rx), .tx_pin(tx), .tx_pin_oe_n(oen), .irq_request(irq));
    au9_serial_peer peer (.clk(clk), .tx_line(tx), .rx_line(rx));
    task chk(input logic [31:0] s, e);
        compares++;
        if (s !== e) begin
            num_errors++;
            $display("Error %0t: got %h expected %h", $time, s, e);
        end
    endtask
    // one classic bus cycle, held until ack
    task bus(input logic w, input logic [5:0] a, input logic [7:0] v);
        @(posedge clk);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, 24'h000000, v};
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        q = rdat;
        {cyc, stb} <= 2'b00;
    endtask
    task run(input int lo, hi);
        for (int i = lo; i <= hi; i++) begin
            bus(rows[i][23], rows[i][21:16], rows[i][15:8]);
            if (!rows[i][23])
                chk(q, rows[i][7:0]);
        end
    endtask
    task wrap_up;
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // cycle ceiling against hangs
    always @(posedge clk) begin
        ticks++;
        if (ticks == 5000) begin
            num_errors++;
            wrap_up;
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        chk({irq, oen, tx}, 3'b011);
        rst_n <= 1;
        run(0, 11);
        chk(irq, 1'b1);
        $display("register table done");
        // ninth bit is written before the data byte
        fork
            peer.recv(d, stp);
            bus(1'b1, 6'h14, 8'ha5);
        join
        chk({stp, d}, 10'h3a5);
        // ninth bit 0 tells a nine-bit frame apart from an eight-bit one
        bus(1'b1, 6'h00, 8'h60);
        fork
            peer.recv(d, stp);
            bus(1'b1, 6'h14, 8'h5a);
        join
        chk({stp, d}, 10'h25a);
        $display("nine-bit send done");
        peer.send(8'h3c, 1'b1);
        peer.send(8'hc3, 1'b0);
        peer.send(8'h5a, 1'b1);
        run(12, 15);
        // overrun still set, so this character is dropped
        peer.send(8'h66, 1'b1);
        run(16, 19);
        $display("receive done");
        // reception restarts after the overrun clear
        peer.send(8'h81, 1'b1);
        bus(1'b0, 6'h18, 8'h00);
        chk(q, 32'h81);
        peer.send(8'h7e, 1'b0);
        bus(1'b0, 6'h04, 8'h00);
        chk(q, 32'h94);
        bus(1'b1, 6'h04, 8'h10);
        bus(1'b0, 6'h04, 8'h00);
        chk(q, 32'h10);
        $display("restart and port reset done");
        wrap_up;
    end
endmodule
`default_nettype wire
